// >>> hdl/sdo_map.svh
// Register map, field positions and reset values of the deserializer override block.
// Assumes inclusion by bare name from any file that needs the constants.
`ifndef SDO_MAP_SVH
`define SDO_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SDO_OFS_MODE 8'h21
`define SDO_OFS_OVERRIDE 8'h22
`define SDO_OFS_LVDS_ONE 8'h27

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SDO_MODE_FIELD_HI 1
`define SDO_MODE_FIELD_LO 0
`define SDO_MODE_MUX_SEL_BIT 4
`define SDO_OVR_MODE_BIT 0
`define SDO_OVR_MUX_BIT 4
`define SDO_LVDS_SWING_BIT 7
`define SDO_LVDS_SWCTRL_BIT 6
`define SDO_LVDS_CLK_EN_BIT 5
`define SDO_LVDS_LANE_HI 4
`define SDO_LVDS_LANE_LO 0

// ----------------------------------------------------------------------
// Encodings, masks and reset values
// ----------------------------------------------------------------------
`define SDO_MODE_ASI_CODE 2'h3
`define SDO_MODE_WMASK 8'h13
`define SDO_OVR_WMASK 8'h11
`define SDO_LVDS_WMASK 8'hFF
`define SDO_REG_RESET 8'h00
`define SDO_RD_UNMAPPED 8'h00
`define SDO_LANE_ALL_ON 5'h1F

`endif

// >>> hdl/sdo_pkg.sv
// Types shared by the deserializer override block.
// Assumes the constants of sdo_map.svh for field widths.
package sdo_pkg;

    // Transport mode that the datapath is steered into.
    typedef enum logic {
        SDO_VIDEO,
        SDO_ASI
    } sdo_mode_t;

    // Registered output and read-back state of the top module; the configuration bytes live in sdo_reg.
    typedef struct packed {
        logic [7:0] rd_data;
        sdo_mode_t mode;
        logic mux_sel;
        logic high_swing;
        logic clk_drv_en;
        logic [4:0] lane_drv_en;
    } sdo_state_t;

    // State of one configuration byte.
    typedef struct packed {
        logic [7:0] value;
    } sdo_byte_t;

endpackage

// >>> hdl/sdo_reg.sv
// One writable configuration byte with a write mask.
// Assumes a single-cycle write strobe synchronous to mclk.
`timescale 1ns/10ps
`include "sdo_map.svh"
module sdo_reg #(
    parameter logic [7:0] WMASK = 8'hFF
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value
);
    sdo_pkg::sdo_byte_t state_q;
    sdo_pkg::sdo_byte_t state_d;

    // Bits outside the mask are reserved and always read as zero.
    always_comb begin
        state_d = state_q;
        if (wr_en) begin
            state_d.value = wr_data & WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q.value <= `SDO_REG_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign value = state_q.value;
endmodule

// >>> hdl/sdo_top.sv
// Mode, input-select override and first LVDS control byte of the deserializer.
// Assumes the serial configuration engine presents decoded single-cycle strobes.
`timescale 1ns/10ps
`include "sdo_map.svh"
module sdo_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    input wire logic mode_select_pin,
    input wire logic input_select_pin,
    output logic transport_mode_asi,
    output logic input_mux_sel,
    output logic high_swing_enable,
    output logic recovered_clock_pair_en,
    output logic [4:0] data_lane_en
);
    // ------------------------------------------------------------------
    // Configuration bytes
    // ------------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] ovr_q;
    logic [7:0] lvds_q;
    logic wr_mode;
    logic wr_ovr;
    logic wr_lvds;

    assign wr_mode = reg_wr_en && (reg_addr == `SDO_OFS_MODE);
    assign wr_ovr = reg_wr_en && (reg_addr == `SDO_OFS_OVERRIDE);
    assign wr_lvds = reg_wr_en && (reg_addr == `SDO_OFS_LVDS_ONE);

    // mode field and register mux select
    sdo_reg #(
        .WMASK(`SDO_MODE_WMASK)
    ) u_mode (
        .mclk(mclk),
        .reset(reset),
        .wr_en(wr_mode),
        .wr_data(reg_wr_data),
        .value(mode_q)
    );

    sdo_reg #(
        .WMASK(`SDO_OVR_WMASK)
    ) u_ovr (
        .mclk(mclk),
        .reset(reset),
        .wr_en(wr_ovr),
        .wr_data(reg_wr_data),
        .value(ovr_q)
    );

    sdo_reg #(
        .WMASK(`SDO_LVDS_WMASK)
    ) u_lvds (
        .mclk(mclk),
        .reset(reset),
        .wr_en(wr_lvds),
        .wr_data(reg_wr_data),
        .value(lvds_q)
    );

    // ------------------------------------------------------------------
    // Output steering
    // ------------------------------------------------------------------
    sdo_pkg::sdo_state_t state_q;
    sdo_pkg::sdo_state_t state_d;

    always_comb begin
        state_d = state_q;
        // A read that meets a write in one cycle returns the old value.
        if (reg_rd_en) begin
            unique case (reg_addr)
                `SDO_OFS_MODE: state_d.rd_data = mode_q;
                `SDO_OFS_OVERRIDE: state_d.rd_data = ovr_q;
                `SDO_OFS_LVDS_ONE: state_d.rd_data = lvds_q;
                default: state_d.rd_data = `SDO_RD_UNMAPPED;
            endcase
        end
        // pin or register decides the mode
        if (ovr_q[`SDO_OVR_MODE_BIT]) begin
            // only code 11 selects serial transport
            if (mode_q[`SDO_MODE_FIELD_HI:`SDO_MODE_FIELD_LO] == `SDO_MODE_ASI_CODE) begin
                state_d.mode = sdo_pkg::SDO_ASI;
            end else begin
                state_d.mode = sdo_pkg::SDO_VIDEO;
            end
        end else if (mode_select_pin) begin
            state_d.mode = sdo_pkg::SDO_ASI;
        end else begin
            state_d.mode = sdo_pkg::SDO_VIDEO;
        end
        // register select under override, pin otherwise
        if (ovr_q[`SDO_OVR_MUX_BIT]) begin
            state_d.mux_sel = mode_q[`SDO_MODE_MUX_SEL_BIT];
        end else begin
            state_d.mux_sel = input_select_pin;
        end
        state_d.high_swing = lvds_q[`SDO_LVDS_SWING_BIT];
        // software takes the drivers, otherwise all stay enabled
        if (lvds_q[`SDO_LVDS_SWCTRL_BIT]) begin
            state_d.clk_drv_en = lvds_q[`SDO_LVDS_CLK_EN_BIT];
            // lanes four and three, lanes two to zero
            state_d.lane_drv_en = lvds_q[`SDO_LVDS_LANE_HI:`SDO_LVDS_LANE_LO];
        end else begin
            state_d.clk_drv_en = 1'b1;
            state_d.lane_drv_en = `SDO_LANE_ALL_ON;
        end
    end

    // Drivers come out of reset enabled, matching the hardware default.
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q.rd_data <= `SDO_RD_UNMAPPED;
            state_q.mode <= sdo_pkg::SDO_VIDEO;
            state_q.mux_sel <= 1'b0;
            state_q.high_swing <= 1'b0;
            state_q.clk_drv_en <= 1'b1;
            state_q.lane_drv_en <= `SDO_LANE_ALL_ON;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rd_data = state_q.rd_data;
    assign transport_mode_asi = (state_q.mode == sdo_pkg::SDO_ASI);
    assign input_mux_sel = state_q.mux_sel;
    assign high_swing_enable = state_q.high_swing;
    assign recovered_clock_pair_en = state_q.clk_drv_en;
    assign data_lane_en = state_q.lane_drv_en;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_wr_lvds;
        reg_wr_en && (reg_addr == `SDO_OFS_LVDS_ONE);
    endsequence

    sequence s_wr_mode;
        reg_wr_en && (reg_addr == `SDO_OFS_MODE);
    endsequence

    a_mode_asi_code: assert property (@(posedge mclk) disable iff (reset)
        (ovr_q[0] && mode_q[1:0] == 2'h3) |=> transport_mode_asi)
        else $error("Mode code 11 did not select serial transport.");

    a_mode_video_code: assert property (@(posedge mclk) disable iff (reset)
        (ovr_q[0] && mode_q[1:0] != 2'h3) |=> !transport_mode_asi)
        else $error("Mode code below 11 did not select video.");

    a_mode_pin_follow: assert property (@(posedge mclk) disable iff (reset)
        !ovr_q[0] |=> (transport_mode_asi == $past(mode_select_pin)))
        else $error("Mode output does not follow the mode pin.");

    a_mux_reg_path: assert property (@(posedge mclk) disable iff (reset)
        (s_wr_mode ##1 ovr_q[4]) |=> (input_mux_sel == $past(reg_wr_data[4], 2)))
        else $error("Mux select ignores the register bit under override.");

    a_mux_pin_path: assert property (@(posedge mclk) disable iff (reset)
        !ovr_q[4] |=> (input_mux_sel == $past(input_select_pin)))
        else $error("Mux select does not follow the select pin.");

    a_mux_sel_bit: assert property (@(posedge mclk) disable iff (reset)
        ovr_q[4] |=> (input_mux_sel == $past(mode_q[4])))
        else $error("Mux select differs from the stored select bit.");

    a_swing_write: assert property (@(posedge mclk) disable iff (reset)
        s_wr_lvds |-> ##2 (high_swing_enable == $past(reg_wr_data[7], 2)))
        else $error("Swing boost does not track the written bit.");

    a_swctrl_clock: assert property (@(posedge mclk) disable iff (reset)
        lvds_q[6] |=> (recovered_clock_pair_en == $past(lvds_q[5])))
        else $error("Clock pair enable ignores its register bit.");

    a_swctrl_upper: assert property (@(posedge mclk) disable iff (reset)
        (s_wr_lvds ##1 lvds_q[6]) |=> (data_lane_en[4:3] == $past(reg_wr_data[4:3], 2)))
        else $error("Upper lane enables do not track the register.");

    a_swctrl_lower: assert property (@(posedge mclk) disable iff (reset)
        lvds_q[6] |=> (data_lane_en[2:0] == $past(lvds_q[2:0])))
        else $error("Lower lane enables do not track the register.");

    a_swctrl_handoff: assert property (@(posedge mclk) disable iff (reset)
        $rose(lvds_q[6]) |-> ##1 ({recovered_clock_pair_en, data_lane_en} == $past(lvds_q[5:0])))
        else $error("Drivers not handed to the register on software control.");

    a_driver_default: assert property (@(posedge mclk) disable iff (reset)
        !lvds_q[6] |=> (recovered_clock_pair_en && data_lane_en == 5'h1F))
        else $error("Drivers not all enabled without software control.");

    a_read_reserved: assert property (@(posedge mclk) disable iff (reset)
        (reg_rd_en && reg_addr == `SDO_OFS_MODE) |=> (reg_rd_data[7:5] == 3'h0))
        else $error("Reserved mode bits read nonzero.");
endmodule

// >>> dv/sdo_host.sv
// Host model that issues register strobes to the override block.
// Assumes each task is entered just after a rising mclk edge.
`timescale 1ns/10ps
module sdo_host (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rd_data
);
    // Released lines show the inverse of the last value, so nothing stale looks valid.
    initial begin
        reg_addr = 8'hFF;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~d;
        @(posedge mclk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = reg_rd_data;
        @(posedge mclk);
        #1;
    endtask
endmodule

// >>> dv/test_sdo_top.sv
// Self-checking bench for the override and LVDS control block.
// Assumes the host model in sdo_host.sv drives the register strobes.
`timescale 1ns/10ps
module test_sdo_top;
    logic mclk;
    logic reset;
    logic [7:0] reg_addr;
    logic reg_wr_en;
    logic [7:0] reg_wr_data;
    logic reg_rd_en;
    logic [7:0] reg_rd_data;
    logic mode_select_pin;
    logic input_select_pin;
    logic transport_mode_asi;
    logic input_mux_sel;
    logic high_swing_enable;
    logic recovered_clock_pair_en;
    logic [4:0] data_lane_en;
    int num_errors;
    int checks;
    int cycles;
    logic [7:0] rv;

    sdo_top sdo_top_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .mode_select_pin(mode_select_pin),
        .input_select_pin(input_select_pin), .transport_mode_asi(transport_mode_asi),
        .input_mux_sel(input_mux_sel), .high_swing_enable(high_swing_enable),
        .recovered_clock_pair_en(recovered_clock_pair_en), .data_lane_en(data_lane_en));
    sdo_host sdo_host_i (.mclk(mclk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));

    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic step(input logic m, input logic s);
        mode_select_pin = m;
        input_select_pin = s;
        @(posedge mclk);
        #1;
    endtask

    // The whole sequence needs under a hundred cycles; the ceiling leaves ample margin.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        mode_select_pin = 1'b0;
        input_select_pin = 1'b0;
        cycles = 0;
        num_errors = 0;
        checks = 0;
        repeat (4) @(posedge mclk);
        #1;
        reset = 1'b0;
        check(8'(recovered_clock_pair_en), 8'h01);
        check(8'(data_lane_en), 8'h1F);
        check(8'(high_swing_enable), 8'h00);
        check(8'(transport_mode_asi), 8'h00);
        check(8'(input_mux_sel), 8'h00);
        sdo_host_i.rd(8'h21, rv);
        check(rv, 8'h00);
        sdo_host_i.rd(8'h22, rv);
        check(rv, 8'h00);
        sdo_host_i.rd(8'h27, rv);
        check(rv, 8'h00);
        sdo_host_i.wr(8'h21, 8'hFF);
        sdo_host_i.rd(8'h21, rv);
        check(rv, 8'h13);
        sdo_host_i.wr(8'h22, 8'hFF);
        sdo_host_i.rd(8'h22, rv);
        check(rv, 8'h11);
        sdo_host_i.wr(8'h23, 8'hFF);
        sdo_host_i.rd(8'h23, rv);
        check(rv, 8'h00);
        sdo_host_i.rd(8'h27, rv);
        check(rv, 8'h00);
        sdo_host_i.wr(8'h22, 8'h00);
        sdo_host_i.wr(8'h21, 8'h00);
        step(1'b1, 1'b0);
        check(8'(transport_mode_asi), 8'h01);
        step(1'b0, 1'b0);
        check(8'(transport_mode_asi), 8'h00);
        sdo_host_i.wr(8'h22, 8'h01);
        for (int v = 0; v < 4; v++) begin
            step(v != 3, 1'b0);
            sdo_host_i.wr(8'h21, 8'(v));
            check(8'(transport_mode_asi), 8'(v == 3));
        end
        sdo_host_i.wr(8'h22, 8'h00);
        sdo_host_i.wr(8'h21, 8'h10);
        step(1'b0, 1'b0);
        check(8'(input_mux_sel), 8'h00);
        step(1'b0, 1'b1);
        check(8'(input_mux_sel), 8'h01);
        sdo_host_i.wr(8'h22, 8'h10);
        sdo_host_i.wr(8'h21, 8'h00);
        check(8'(input_mux_sel), 8'h00);
        sdo_host_i.wr(8'h21, 8'h10);
        step(1'b0, 1'b0);
        check(8'(input_mux_sel), 8'h01);
        sdo_host_i.wr(8'h27, 8'h80);
        check(8'(high_swing_enable), 8'h01);
        check(8'(recovered_clock_pair_en), 8'h01);
        check(8'(data_lane_en), 8'h1F);
        for (int i = 0; i < 6; i++) begin
            sdo_host_i.wr(8'h27, 8'h40 | 8'(1 << i));
            check(8'(data_lane_en), 8'(1 << i) & 8'h1F);
            check(8'(recovered_clock_pair_en), 8'(i == 5));
            check(8'(high_swing_enable), 8'h00);
            sdo_host_i.rd(8'h27, rv);
            check(rv, 8'h40 | 8'(1 << i));
        end
        reset = 1'b1;
        step(1'b0, 1'b0);
        reset = 1'b0;
        check(8'(data_lane_en), 8'h1F);
        sdo_host_i.rd(8'h27, rv);
        check(rv, 8'h00);
        print_verdict();
    end
endmodule
